// ==== core/dbs_params.svh ====
// Offsets, field positions, reset values and vectors of the debug status block
`ifndef DBS_PARAMS_SVH
`define DBS_PARAMS_SVH

// Register offset
`define DBS_DEBUG_STATUS_OFS 8'h00
`define DBS_RESET_VAL        32'h0000_0000

// Field positions
`define DBS_BIT_DBG_MODE    30
`define DBS_BIT_OTHER_EXC   12
`define DBS_BIT_TLB_FLAG    11
`define DBS_BIT_BUS_FLAG    10
`define DBS_BIT_STEP_EN     8
`define DBS_BIT_SCAN_RST    7
`define DBS_BIT_IRQ_CAUSE   5
`define DBS_BIT_IBRK_CAUSE  4
`define DBS_BIT_SBRK_CAUSE  3
`define DBS_BIT_LBRK_CAUSE  2
`define DBS_BIT_SWBRK_CAUSE 1
`define DBS_BIT_STEP_CAUSE  0

// Return vectors for a coincident other exception
`define DBS_OTHER_VEC_BOOT1 32'hBFC0_0380
`define DBS_OTHER_VEC_BOOT0 32'h8000_0180

// Number of cause bits (bits 5..0)
`define DBS_NCAUSE 6

`endif

// ==== core/dbs_pkg.sv ====
// Types of the debug status block
package dbs_pkg;
    typedef enum logic [1:0] {
        DBS_NORMAL,
        DBS_HANDLER
    } dbs_mode_t;
endpackage

// ==== core/dbs_sticky.sv ====
// One sticky status flag: hardware set wins over software clear-by-zero
`timescale 1ns/1ps
`default_nettype none
module dbs_sticky (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Set and clear
    input  wire logic set,
    input  wire logic clr,
    // State
    output logic      flag_ff
);
    // Set has priority so a coinciding event is never lost
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_ff <= 1'b0;
        end else if (set) begin
            flag_ff <= 1'b1;
        end else if (clr) begin
            flag_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== core/dbs_debug_status.sv ====
// Bits 30 and 12:0 of the debug status register with debug mode tracking
`timescale 1ns/1ps
`default_nettype none
`include "dbs_params.svh"

module dbs_debug_status (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata_ff,
    // Debug exception entry and cause
    input  wire logic        dbg_exc_take,
    input  wire logic        cause_debug_irq,
    input  wire logic        cause_instr_break,
    input  wire logic        cause_store_break,
    input  wire logic        cause_load_break,
    input  wire logic        cause_sw_break,
    input  wire logic        cause_step,
    input  wire logic        other_exc,
    input  wire logic        debug_return_instr,
    // Faults while in the handler
    input  wire logic        ls_tlb_exc,
    input  wire logic        ls_bus_err,
    // Boot vector select from status logic
    input  wire logic        boot_vector_select,
    // Control outputs
    output logic             debug_mode_flag_ff,
    output logic             step_active_ff,
    output logic             scan_unit_reset_ff,
    output logic             debug_return_pc_hold_ff,
    output logic [31:0]      other_vector_ff
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic        hit_status;
    wire logic        wr_status;
    wire logic        tlb_flag_clr;
    wire logic        bus_flag_clr;
    wire logic        tlb_flag_set;
    wire logic        bus_flag_set;
    wire logic [`DBS_NCAUSE-1:0] cause_vec;
    wire logic [`DBS_NCAUSE-1:0] cause_q;
    wire logic        tlb_flag_q;
    wire logic        bus_flag_q;
    wire logic [31:0] status_word;
    wire logic [31:0] nxt_rdata;
    wire logic        nxt_step_active;

    logic             other_coin_ff;
    logic             step_en_ff;
    dbs_pkg::dbs_mode_t mode_ff;

    assign hit_status = (reg_addr == `DBS_DEBUG_STATUS_OFS);
    assign wr_status  = reg_wr & hit_status;
    // Faults only count while the handler runs
    assign tlb_flag_set = ls_tlb_exc & debug_mode_flag_ff;
    assign bus_flag_set = ls_bus_err & debug_mode_flag_ff;
    assign tlb_flag_clr = wr_status & ~reg_wdata[`DBS_BIT_TLB_FLAG];
    assign bus_flag_clr = wr_status & ~reg_wdata[`DBS_BIT_BUS_FLAG];

    // Cause bits in bit order 5..0
    assign cause_vec = {cause_debug_irq,
                        cause_instr_break,
                        cause_store_break,
                        cause_load_break,
                        cause_sw_break,
                        cause_step};

    // ------------------------------------------------------------
    // Sticky fault flags
    // ------------------------------------------------------------
    dbs_sticky u_tlb_flag (
        .clk     (clk),
        .rst     (rst),
        .set     (tlb_flag_set),
        .clr     (tlb_flag_clr),
        .flag_ff (tlb_flag_q)
    );

    dbs_sticky u_bus_flag (
        .clk     (clk),
        .rst     (rst),
        .set     (bus_flag_set),
        .clr     (bus_flag_clr),
        .flag_ff (bus_flag_q)
    );

    // ------------------------------------------------------------
    // Cause bits: reloaded at each debug exception taken outside the handler, not software writable
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `DBS_NCAUSE; gi = gi + 1) begin : g_cause
            logic cb_ff;
            // Each entry records a fresh cause set, so stale causes drop out
            always_ff @(posedge clk) begin
                if (rst) begin
                    cb_ff <= 1'b0;
                end else if (dbg_exc_take & ~debug_mode_flag_ff) begin
                    cb_ff <= cause_vec[gi];
                end
            end
            assign cause_q[gi] = cb_ff;
        end
    endgenerate

    // Coincident other exception, captured on entry
    always_ff @(posedge clk) begin
        if (rst) begin
            other_coin_ff <= 1'b0;
        end else if (dbg_exc_take & ~debug_mode_flag_ff) begin
            other_coin_ff <= other_exc;
        end
    end

    // ------------------------------------------------------------
    // Debug mode tracking
    // ------------------------------------------------------------
    // Nested debug exceptions are masked in the handler, so entry is ignored there
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_ff            <= dbs_pkg::DBS_NORMAL;
            debug_mode_flag_ff <= 1'b0;
        end else begin
            case (mode_ff)
                dbs_pkg::DBS_NORMAL: begin
                    if (dbg_exc_take) begin
                        mode_ff            <= dbs_pkg::DBS_HANDLER;
                        debug_mode_flag_ff <= 1'b1;
                    end
                end
                dbs_pkg::DBS_HANDLER: begin
                    if (debug_return_instr) begin
                        mode_ff            <= dbs_pkg::DBS_NORMAL;
                        debug_mode_flag_ff <= 1'b0;
                    end
                end
                default: begin
                    mode_ff            <= dbs_pkg::DBS_NORMAL;
                    debug_mode_flag_ff <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Writable controls
    // ------------------------------------------------------------
    // Only bits 11, 10, 8 and 7 accept writes; the rest are ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            step_en_ff         <= 1'b0;
            scan_unit_reset_ff <= 1'b0;
        end else if (wr_status) begin
            step_en_ff         <= reg_wdata[`DBS_BIT_STEP_EN];
            scan_unit_reset_ff <= reg_wdata[`DBS_BIT_SCAN_RST];
        end
    end

    // Stepping drops out one cycle after handler entry and stays off there, whatever the enable says
    assign nxt_step_active = step_en_ff & ~debug_mode_flag_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            step_active_ff <= 1'b0;
        end else begin
            step_active_ff <= nxt_step_active;
        end
    end

    // ------------------------------------------------------------
    // Return PC handling for coincident exceptions
    // ------------------------------------------------------------
    // Hold keeps the other exception's vector out of the return PC; the
    // suggested vector is offered for handler software to load itself
    always_ff @(posedge clk) begin
        if (rst) begin
            debug_return_pc_hold_ff <= 1'b0;
            other_vector_ff         <= `DBS_RESET_VAL;
        end else begin
            debug_return_pc_hold_ff <= dbg_exc_take & other_exc
                                       & ~debug_mode_flag_ff;
            other_vector_ff         <= boot_vector_select ? `DBS_OTHER_VEC_BOOT1
                                                          : `DBS_OTHER_VEC_BOOT0;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Bits 31, 29:13 belong elsewhere or are reserved and read zero
    assign status_word = {1'b0, debug_mode_flag_ff, 17'h0_0000,
                          other_coin_ff, tlb_flag_q, bus_flag_q, 1'b0, step_en_ff,
                          scan_unit_reset_ff, 1'b0, cause_q};
    assign nxt_rdata   = (reg_rd & hit_status) ? status_word : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata_ff <= `DBS_RESET_VAL;
        end else begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_tlb_set;
        @(posedge clk) disable iff (rst)
        tlb_flag_set |=> tlb_flag_q;
    endproperty
    a_tlb_set: assert property (p_tlb_set) else $error("tlb flag not set");

    // A fault outside the handler must leave a clear flag clear
    property p_tlb_out;
        @(posedge clk) disable iff (rst)
        (ls_tlb_exc & ~debug_mode_flag_ff & ~tlb_flag_q) |=> ~tlb_flag_q;
    endproperty
    a_tlb_out: assert property (p_tlb_out) else $error("tlb flag set outside handler");

    property p_tlb_clr;
        @(posedge clk) disable iff (rst)
        (tlb_flag_clr & ~tlb_flag_set) |=> ~tlb_flag_q;
    endproperty
    a_tlb_clr: assert property (p_tlb_clr) else $error("tlb flag not cleared");

    property p_tlb_one;
        @(posedge clk) disable iff (rst)
        (wr_status & reg_wdata[`DBS_BIT_TLB_FLAG] & ~tlb_flag_set) |=> (tlb_flag_q == $past(tlb_flag_q));
    endproperty
    a_tlb_one: assert property (p_tlb_one) else $error("tlb flag changed on one");

    property p_bus_set;
        @(posedge clk) disable iff (rst)
        (ls_bus_err & debug_mode_flag_ff) |=> bus_flag_q;
    endproperty
    a_bus_set: assert property (p_bus_set) else $error("bus flag not set");

    property p_bus_clr;
        @(posedge clk) disable iff (rst)
        (bus_flag_clr & ~bus_flag_set) |=> ~bus_flag_q;
    endproperty
    a_bus_clr: assert property (p_bus_clr) else $error("bus flag not cleared");

    property p_bus_one;
        @(posedge clk) disable iff (rst)
        (wr_status & reg_wdata[`DBS_BIT_BUS_FLAG] & ~bus_flag_set) |=> (bus_flag_q == $past(bus_flag_q));
    endproperty
    a_bus_one: assert property (p_bus_one) else $error("bus flag changed on one");

    property p_step_off;
        @(posedge clk) disable iff (rst)
        debug_mode_flag_ff |=> ~step_active_ff;
    endproperty
    a_step_off: assert property (p_step_off) else $error("step active in handler");

    property p_ctrl_wr;
        @(posedge clk) disable iff (rst)
        wr_status |=> (step_en_ff == $past(reg_wdata[`DBS_BIT_STEP_EN]))
                      && (scan_unit_reset_ff == $past(reg_wdata[`DBS_BIT_SCAN_RST]));
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

    property p_entry;
        @(posedge clk) disable iff (rst)
        (dbg_exc_take & ~debug_mode_flag_ff) |=> debug_mode_flag_ff
            && (cause_q == $past(cause_vec)) && (other_coin_ff == $past(other_exc));
    endproperty
    a_entry: assert property (p_entry) else $error("entry capture wrong");

    // Inside the handler the recorded causes and coincidence bit stay put
    property p_nest_keep;
        @(posedge clk) disable iff (rst)
        debug_mode_flag_ff |=> (cause_q == $past(cause_q)) && (other_coin_ff == $past(other_coin_ff));
    endproperty
    a_nest_keep: assert property (p_nest_keep) else $error("status changed in handler");

    property p_mode_exit;
        @(posedge clk) disable iff (rst)
        (debug_mode_flag_ff & debug_return_instr) |=> ~debug_mode_flag_ff;
    endproperty
    a_mode_exit: assert property (p_mode_exit) else $error("mode kept after return");

    property p_other_hold;
        @(posedge clk) disable iff (rst)
        (dbg_exc_take & other_exc & ~debug_mode_flag_ff) |=> debug_return_pc_hold_ff;
    endproperty
    a_other_hold: assert property (p_other_hold) else $error("return pc not held");

    property p_other_vec;
        @(posedge clk) disable iff (rst)
        1'b1 |=> (other_vector_ff == ($past(boot_vector_select) ? `DBS_OTHER_VEC_BOOT1
                                                                : `DBS_OTHER_VEC_BOOT0));
    endproperty
    a_other_vec: assert property (p_other_vec) else $error("suggested vector wrong");

    property p_ro;
        @(posedge clk) disable iff (rst)
        (wr_status & ~dbg_exc_take) |=> (cause_q == $past(cause_q));
    endproperty
    a_ro: assert property (p_ro) else $error("read-only bits written");

    property p_read;
        @(posedge clk) disable iff (rst)
        (reg_rd & hit_status) |=> (reg_rdata_ff[29:13] == 17'h0_0000) && (reg_rdata_ff[9] == 1'b0);
    endproperty
    a_read: assert property (p_read) else $error("reserved bits nonzero");

    // Read data stand for one cycle only, zero elsewhere
    property p_rdata_idle;
        @(posedge clk) disable iff (rst)
        ~(reg_rd & hit_status) |=> (reg_rdata_ff == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

    c_entry:  cover property (@(posedge clk) disable iff (rst) dbg_exc_take ##[1:20] debug_return_instr);
    c_tlb:    cover property (@(posedge clk) disable iff (rst) tlb_flag_set && tlb_flag_clr);
    c_other:  cover property (@(posedge clk) disable iff (rst) dbg_exc_take && other_exc);
    c_step:   cover property (@(posedge clk) disable iff (rst) step_active_ff);

endmodule
`default_nettype wire

// ==== tb/dbs_debug_status_bench.sv ====
// Self-checking bench for the debug status register block
`timescale 1ns/1ps
`default_nettype none
`include "dbs_params.svh"
module dbs_debug_status_bench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata_ff;
    logic        dbg_exc_take;
    logic [5:0]  cause_vec;
    logic        other_exc;
    logic        debug_return_instr;
    logic        ls_tlb_exc;
    logic        ls_bus_err;
    logic        boot_vector_select;
    logic        debug_mode_flag_ff;
    logic        step_active_ff;
    logic        scan_unit_reset_ff;
    logic        debug_return_pc_hold_ff;
    logic [31:0] other_vector_ff;
    logic [31:0] rd;
    int          n_fail;
    int          total_checks;
    int          cycles;
    localparam logic [31:0] MODE_BIT = 32'h4000_0000;

    dbs_debug_status i_dut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .dbg_exc_take(dbg_exc_take),
        .cause_debug_irq(cause_vec[5]), .cause_instr_break(cause_vec[4]),
        .cause_store_break(cause_vec[3]), .cause_load_break(cause_vec[2]),
        .cause_sw_break(cause_vec[1]), .cause_step(cause_vec[0]), .other_exc(other_exc),
        .debug_return_instr(debug_return_instr), .ls_tlb_exc(ls_tlb_exc), .ls_bus_err(ls_bus_err),
        .boot_vector_select(boot_vector_select), .debug_mode_flag_ff(debug_mode_flag_ff),
        .step_active_ff(step_active_ff), .scan_unit_reset_ff(scan_unit_reset_ff),
        .debug_return_pc_hold_ff(debug_return_pc_hold_ff), .other_vector_ff(other_vector_ff)
    );

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole run is well under a thousand cycles, so this ceiling only trips on a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            $display("[FAIL] %0t timeout", $time);
            n_fail++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Bus, event and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_ff;
    endtask
    task automatic read_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        reg_read(a, rd);
        chk(rd, exp, msg);
    endtask
    task automatic ev_take(input logic [5:0] c, input logic oth);
        @(posedge clk);
        dbg_exc_take <= 1'b1;
        cause_vec    <= c;
        other_exc    <= oth;
        @(posedge clk);
        dbg_exc_take <= 1'b0;
        cause_vec    <= 6'h00;
        other_exc    <= 1'b0;
        #1;
    endtask
    task automatic ev_ret();
        @(posedge clk);
        debug_return_instr <= 1'b1;
        @(posedge clk);
        debug_return_instr <= 1'b0;
        #1;
    endtask
    // Faults may share their edge with a zero write, the race the flags must survive
    task automatic fault(input logic t, input logic b, input logic wr0);
        @(posedge clk);
        ls_tlb_exc <= t;
        ls_bus_err <= b;
        reg_wr     <= wr0;
        reg_addr   <= 8'h00;
        reg_wdata  <= 32'h0;
        @(posedge clk);
        ls_tlb_exc <= 1'b0;
        ls_bus_err <= 1'b0;
        reg_wr     <= 1'b0;
        #1;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        read_chk(8'h00, 32'h0, "reset word");
        chk({31'h0, debug_mode_flag_ff}, 32'h0, "reset mode");
        reg_write(8'h04, 32'hFFFF_FFFF);
        read_chk(8'h04, 32'h0, "unmapped");
        read_chk(8'h00, 32'h0, "unmapped write ignored");
        $display("t_reset done");
    endtask
    task automatic t_control();
        reg_write(8'h00, 32'hFFFF_FFFF);
        read_chk(8'h00, 32'h0000_0180, "only controls take writes");
        chk({31'h0, scan_unit_reset_ff}, 32'h1, "scan reset on");
        chk({31'h0, step_active_ff}, 32'h1, "step on");
        reg_write(8'h00, 32'h0);
        read_chk(8'h00, 32'h0, "controls off");
        chk({31'h0, scan_unit_reset_ff}, 32'h0, "scan reset off");
        $display("t_control done");
    endtask
    task automatic t_causes();
        logic [31:0] exp;
        reg_write(8'h00, 32'h0000_0100);
        for (int i = 0; i < 6; i++) begin
            exp = MODE_BIT | 32'h0000_0100 | (32'h1 << i);
            ev_take(6'h01 << i, 1'b0);
            chk({31'h0, debug_mode_flag_ff}, 32'h1, "mode on entry");
            read_chk(8'h00, exp, "cause");
            chk({31'h0, step_active_ff}, 32'h0, "step held off");
            // A second entry inside the handler must not disturb the recorded cause
            ev_take(6'h01 << ((i + 1) % 6), 1'b1);
            read_chk(8'h00, exp, "nested entry");
            ev_ret();
            chk({31'h0, debug_mode_flag_ff}, 32'h0, "mode off");
            @(posedge clk);
            #1;
            chk({31'h0, step_active_ff}, 32'h1, "step back");
        end
        reg_write(8'h00, 32'h0);
        $display("t_causes done");
    endtask
    task automatic t_other();
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            boot_vector_select <= b[0];
            ev_take(6'h20, 1'b1);
            chk({31'h0, debug_return_pc_hold_ff}, 32'h1, "hold pulse");
            @(posedge clk);
            #1;
            chk({31'h0, debug_return_pc_hold_ff}, 32'h0, "hold one cycle");
            chk(other_vector_ff, b ? `DBS_OTHER_VEC_BOOT1 : `DBS_OTHER_VEC_BOOT0, "vector");
            read_chk(8'h00, MODE_BIT | 32'h1020, "coincident flag");
            ev_ret();
        end
        // A plain entry must neither hold the return PC nor keep the old coincidence bit
        ev_take(6'h01, 1'b0);
        chk({31'h0, debug_return_pc_hold_ff}, 32'h0, "no hold alone");
        read_chk(8'h00, MODE_BIT | 32'h0001, "coincident flag reloaded");
        ev_ret();
        $display("t_other done");
    endtask
    task automatic t_faults();
        // Causes of the last entry stand until the next one; only the flags must stay low
        fault(1'b1, 1'b1, 1'b0);
        read_chk(8'h00, 32'h0000_0001, "faults outside handler");
        ev_take(6'h02, 1'b0);
        fault(1'b1, 1'b1, 1'b0);
        read_chk(8'h00, MODE_BIT | 32'h0C02, "faults in handler");
        reg_write(8'h00, 32'h0000_0C00);
        read_chk(8'h00, MODE_BIT | 32'h0C02, "write one ignored");
        fault(1'b1, 1'b0, 1'b1);
        read_chk(8'h00, MODE_BIT | 32'h0802, "tlb set beats clear");
        fault(1'b0, 1'b1, 1'b1);
        read_chk(8'h00, MODE_BIT | 32'h0402, "bus set beats clear");
        reg_write(8'h00, 32'h0);
        read_chk(8'h00, MODE_BIT | 32'h0002, "flags cleared");
        ev_ret();
        $display("t_faults done");
    endtask

    // ----------------------------------------
    // Verdict and main sequence
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        n_fail             = 0;
        total_checks       = 0;
        cycles             = 0;
        rst                = 1'b1;
        reg_addr           = 8'h00;
        reg_wdata          = 32'h0;
        reg_wr             = 1'b0;
        reg_rd             = 1'b0;
        dbg_exc_take       = 1'b0;
        cause_vec          = 6'h00;
        other_exc          = 1'b0;
        debug_return_instr = 1'b0;
        ls_tlb_exc         = 1'b0;
        ls_bus_err         = 1'b0;
        boot_vector_select = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_control();
        t_causes();
        t_other();
        t_faults();
        tally_and_finish();
    end
endmodule
`default_nettype wire
